/* File: logic/icc_pkg.sv */
package icc_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int ICC_CHANNELS = 8;
    localparam int ICC_DMA_CHANNELS = 2;
    localparam logic [2:0] ICC_DEPTH = 3'h4;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ICC_MAP_END = 8'h40;
    localparam int ICC_REG_SEL_BIT = 2;
    localparam int ICC_CHAN_LSB = 3;

    // ----------------------------------------
    // Control word fields
    // ----------------------------------------
    localparam int ICC_IDLE_STOP_BIT = 13;
    localparam int ICC_TB_SEL_BIT = 7;
    localparam int ICC_CPI_LSB = 5;
    localparam int ICC_OVF_BIT = 4;
    localparam int ICC_BNE_BIT = 3;
    localparam int ICC_MODE_LSB = 0;

    // ----------------------------------------
    // Prescaler terminal counts
    // ----------------------------------------
    localparam logic [3:0] ICC_DIV4_LAST = 4'h3;
    localparam logic [3:0] ICC_DIV16_LAST = 4'hF;

    typedef enum logic [2:0] {
        ICC_OFF = 3'h0,
        ICC_BOTH = 3'h1,
        ICC_FALL = 3'h2,
        ICC_RISE = 3'h3,
        ICC_DIV4 = 3'h4,
        ICC_DIV16 = 3'h5,
        ICC_RSVD = 3'h6,
        ICC_INT_ONLY = 3'h7
    } icc_mode_t;

    typedef struct packed {
        logic idleStop;
        logic timeBaseSel;
        logic [1:0] capturesPerInterruptSelect;
        icc_mode_t mode;
    } icc_ctrl_t;

    localparam icc_ctrl_t ICC_CTRL_RST = '{1'b0, 1'b0, 2'h0, ICC_OFF};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } icc_apb_req_t;

    function automatic logic [2:0] icc_chan_of(input logic [7:0] addr);
        icc_chan_of = addr[ICC_CHAN_LSB+:3];
    endfunction

endpackage

/* File: logic/icc_top.sv */
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module icc_top
(
    input wire logic clock,
    input wire logic rstn,
    input wire icc_pkg::icc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timeBaseACount,
    input wire logic [15:0] timeBaseBCount,
    input wire logic [7:0] captureInputPin,
    input wire logic cpuIdle,
    input wire logic cpuSleep,
    output logic [7:0] captureIrq,
    output logic [1:0] dmaReq,
    output logic wakeReq
);
    import icc_pkg::*;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic popOk_ff;
    logic wake_ff;
    logic [7:0] syncA_ff;
    logic [7:0] syncB_ff;
    logic [7:0] irqVec;
    logic [7:0] wakeVec;
    logic [7:0] bneVec;
    logic [31:0] ctrlWord [ICC_CHANNELS];
    logic [31:0] headWord [ICC_CHANNELS];

    wire access = apbReq.psel & apbReq.penable;
    wire load = access & ~pready_ff;
    wire done = access & pready_ff;
    wire [2:0] chan = icc_chan_of(apbReq.paddr);
    wire regSel = apbReq.paddr[ICC_REG_SEL_BIT];
    wire mapped = (apbReq.paddr < ICC_MAP_END) &
                  (apbReq.paddr[1:0] == 2'h0);

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [31:0] rdMux = regSel ? headWord[chan] : ctrlWord[chan];
    wire rdPop = mapped & ~apbReq.pwrite & regSel & bneVec[chan];

    wire nxt_pready = load;
    wire nxt_pslverr = load & ~mapped;
    wire [31:0] nxt_prdata = load ? (mapped ? rdMux : 32'h0) : prdata_ff;
    wire nxt_popOk = load & rdPop;

    // One wait state so the read word settles before sampling
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata_ff <= 32'h0;
            popOk_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            popOk_ff <= nxt_popOk;
        end
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            syncA_ff <= 8'h0;
            syncB_ff <= 8'h0;
        end
        else
        begin
            syncA_ff <= captureInputPin;
            syncB_ff <= syncA_ff;
        end
    end

    // ----------------------------------------
    // Wake request
    // ----------------------------------------
    // Any enabled channel edge wakes, so idle stop cannot block wake
    wire nxt_wake = |wakeVec;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            wake_ff <= 1'b0;
        else
            wake_ff <= nxt_wake;
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar g = 0; g < ICC_CHANNELS; g++)
    begin : gChan
        // ----------------------------------------
        // Channel state
        // ----------------------------------------
        icc_ctrl_t ctrl_ff;
        logic [15:0] mem_ff [4];
        logic [1:0] wp_ff;
        logic [1:0] rp_ff;
        logic [2:0] fill_ff;
        logic ovf_ff;
        logic [3:0] pre_ff;
        logic [1:0] evCnt_ff;
        logic prev_ff;
        logic irq_ff;

        wire sel = apbReq.paddr < ICC_MAP_END && chan == 3'(g);
        wire wrCtrl = done & apbReq.pwrite & mapped & sel & ~regSel;
        wire pop = done & popOk_ff & sel;
        icc_ctrl_t newCtrl;
        assign newCtrl = '{apbReq.pwdata[ICC_IDLE_STOP_BIT],
                           apbReq.pwdata[ICC_TB_SEL_BIT],
                           apbReq.pwdata[ICC_CPI_LSB+:2],
                           icc_mode_t'(apbReq.pwdata[ICC_MODE_LSB+:3])};
        wire modeChg = wrCtrl & (newCtrl.mode != ctrl_ff.mode);
        wire clearAll = wrCtrl & (newCtrl.mode == ICC_OFF);
        // Halting drops pin edges seen while the processor idles
        wire halt = ctrl_ff.idleStop & cpuIdle;
        wire active = (ctrl_ff.mode != ICC_OFF) & ~halt & ~modeChg;

        // ----------------------------------------
        // Edge select
        // ----------------------------------------
        wire rise = syncB_ff[g] & ~prev_ff;
        wire fall = ~syncB_ff[g] & prev_ff;
        wire [3:0] preLast = (ctrl_ff.mode == ICC_DIV4) ?
                             ICC_DIV4_LAST : ICC_DIV16_LAST;
        wire preHit = rise & (pre_ff == preLast);
        logic edgeSel;
        always_comb
        begin
            case (ctrl_ff.mode)
                ICC_BOTH: edgeSel = rise | fall;
                ICC_FALL: edgeSel = fall;
                ICC_RISE: edgeSel = rise;
                ICC_DIV4: edgeSel = preHit;
                ICC_DIV16: edgeSel = preHit;
                default: edgeSel = 1'b0;
            endcase
        end
        wire capEv = active & edgeSel;
        wire intOnly = active & (ctrl_ff.mode == ICC_INT_ONLY) & rise;
        wire full = fill_ff == ICC_DEPTH;
        wire push = capEv & ~full;
        wire irqHit = capEv & (evCnt_ff == ctrl_ff.capturesPerInterruptSelect);
        wire [15:0] capVal = ctrl_ff.timeBaseSel ?
                             timeBaseACount : timeBaseBCount;

        // ----------------------------------------
        // Channel next state
        // ----------------------------------------
        icc_ctrl_t nxt_ctrl;
        assign nxt_ctrl = wrCtrl ? newCtrl : ctrl_ff;
        // Mode change restarts prescaler and capture count
        wire restart = modeChg | (active & preHit);
        wire [3:0] nxt_pre = restart ? 4'h0 :
                             (active & rise) ? pre_ff + 4'h1 : pre_ff;
        wire [1:0] nxt_evCnt = (modeChg | irqHit) ? 2'h0 :
                               capEv ? evCnt_ff + 2'h1 : evCnt_ff;
        wire nxt_irq = irqHit | intOnly;
        wire [1:0] nxt_wp = clearAll ? 2'h0 : wp_ff + {1'b0, push};
        wire [1:0] nxt_rp = clearAll ? 2'h0 : rp_ff + {1'b0, pop};
        wire [2:0] nxt_fill = clearAll ? 3'h0 :
                              fill_ff + {2'h0, push} - {2'h0, pop};
        // Set beats a pop clear when both land together; clearAll beats set
        wire nxt_ovf = ~clearAll & ((capEv & full) | (ovf_ff & ~pop));

        // ----------------------------------------
        // Channel registers
        // ----------------------------------------
        always_ff @(posedge clock or negedge rstn)
        begin
            if (!rstn)
            begin
                ctrl_ff <= ICC_CTRL_RST;
                prev_ff <= 1'b0;
                irq_ff <= 1'b0;
            end
            else
            begin
                ctrl_ff <= nxt_ctrl;
                prev_ff <= syncB_ff[g];
                irq_ff <= nxt_irq;
            end
        end

        always_ff @(posedge clock or negedge rstn)
        begin
            if (!rstn)
            begin
                pre_ff <= 4'h0;
                evCnt_ff <= 2'h0;
            end
            else
            begin
                pre_ff <= nxt_pre;
                evCnt_ff <= nxt_evCnt;
            end
        end

        always_ff @(posedge clock or negedge rstn)
        begin
            if (!rstn)
            begin
                wp_ff <= 2'h0;
                rp_ff <= 2'h0;
                fill_ff <= 3'h0;
                ovf_ff <= 1'b0;
            end
            else
            begin
                wp_ff <= nxt_wp;
                rp_ff <= nxt_rp;
                fill_ff <= nxt_fill;
                ovf_ff <= nxt_ovf;
            end
        end

        always_ff @(posedge clock)
        begin
            if (push)
                mem_ff[wp_ff] <= capVal;
        end

        // ----------------------------------------
        // Status and read words
        // ----------------------------------------
        assign bneVec[g] = fill_ff != 3'h0;
        assign irqVec[g] = irq_ff;
        assign wakeVec[g] = (cpuSleep | cpuIdle) & (rise | fall) &
                            (ctrl_ff.mode != ICC_OFF);
        assign headWord[g] = bneVec[g] ? {16'h0, mem_ff[rp_ff]} : 32'h0;
        assign ctrlWord[g] = {18'h0, ctrl_ff.idleStop, 5'h0,
                              ctrl_ff.timeBaseSel,
                              ctrl_ff.capturesPerInterruptSelect,
                              ovf_ff, bneVec[g], ctrl_ff.mode};
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign captureIrq = irqVec;
    // Request tracks the interrupt, so one capture per request needs cpi 00
    assign dmaReq = irqVec[ICC_DMA_CHANNELS-1:0];
    assign wakeReq = wake_ff;

endmodule

/* File: sim/icc_pin_model.sv */
`timescale 1ns/1ps
module icc_pin_model
(
    input wire logic clock,
    input wire logic [2:0] chan,
    input wire logic step,
    output logic [7:0] pin
);
    initial pin = 8'h00;
    // Level holds between requested edges
    always @(posedge clock)
        if (step)
            pin[chan] <= ~pin[chan];
endmodule

/* File: sim/icc_top_sva.sv */
`timescale 1ns/1ps
module icc_top_sva
(
    input wire logic clock,
    input wire logic rstn,
    input wire icc_pkg::icc_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] timeBaseACount,
    input wire logic [15:0] timeBaseBCount,
    input wire logic [7:0] captureInputPin,
    input wire logic cpuIdle,
    input wire logic cpuSleep,
    input wire logic [7:0] captureIrq,
    input wire logic [1:0] dmaReq,
    input wire logic wakeReq
);
    import icc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_dma_follows_irq: assert property (
        dmaReq == captureIrq[1:0]) else $error("dma request off irq");
    a_irq_one_pulse: assert property (
        captureIrq[0] |=> !captureIrq[0]) else $error("irq too long");
    a_wake_needs_power: assert property (
        wakeReq |-> $past(cpuIdle || cpuSleep)) else $error("wake awake");
    a_wake_one_pulse: assert property (
        wakeReq |=> !wakeReq) else $error("wake too long");
    a_ready_one_wait: assert property (
        $rose(apbReq.psel && apbReq.penable) |-> !pready ##1 pready)
        else $error("ready timing");
    a_ready_one_cycle: assert property (
        pready |=> !pready) else $error("ready too long");
    a_err_unmapped: assert property (
        pready && apbReq.paddr >= ICC_MAP_END |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_upper_bits_zero: assert property (
        pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
endmodule
bind icc_top icc_top_sva i_sva (.clock(clock), .rstn(rstn),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timeBaseACount(timeBaseACount), .timeBaseBCount(timeBaseBCount),
    .captureInputPin(captureInputPin), .cpuIdle(cpuIdle),
    .cpuSleep(cpuSleep), .captureIrq(captureIrq), .dmaReq(dmaReq),
    .wakeReq(wakeReq));

/* File: sim/icc_top_tb.sv */
`timescale 1ns/1ps
module icc_top_tb;
    import icc_pkg::*;
    logic clock, rstn, pready, pslverr, cpuIdle, cpuSleep, step, wakeReq;
    logic [31:0] prdata;
    logic [15:0] tbA, tbB;
    logic [7:0] pin, captureIrq;
    logic [2:0] chan;
    icc_apb_req_t apbReq;
    logic [32:0] expQ[$];
    int errTotal, numChecks, irqCnt, wakeCnt, curCh;
    icc_top i_dut (.clock(clock), .rstn(rstn), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timeBaseACount(tbA), .timeBaseBCount(tbB),
        .captureInputPin(pin), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
        .captureIrq(captureIrq), .dmaReq(), .wakeReq(wakeReq));
    icc_pin_model i_pin (.clock(clock), .chan(chan), .step(step),
        .pin(pin));
    // ----
    // Checks
    // ----
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] s, e);
        numChecks++;
        if (s !== e)
        begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    always @(posedge clock)
    begin
        if (pready && !apbReq.pwrite)
            chk("read", {pslverr, prdata}, expQ.pop_front());
        irqCnt += captureIrq[curCh];
        wakeCnt += wakeReq;
    end
    // ----
    // Drivers
    // ----
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge clock);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (!pready && n < 50);
        if (!pready)
        begin
            errTotal++;
            tally_and_finish();
        end
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    // Pins toggled 32 times, then FIFO drained and one empty read
    task automatic run(input int ch, input icc_mode_t m, input logic idl);
        logic [15:0] cap[$];
        logic [1:0] cpi;
        logic sel, lvl, slp;
        int rise, nc, nIrq;
        cpi = (ch < 2) ? 2'h0 : 2'($urandom);
        sel = ch[0];
        slp = (ch == 7);
        lvl = 0;
        rise = 0;
        nc = 0;
        curCh = ch;
        chan <= 3'(ch);
        cpuIdle <= idl;
        cpuSleep <= slp;
        apb(1, 8'(ch * 8), {18'h0, idl, 5'h0, sel, cpi, 2'h0, m});
        irqCnt = 0;
        wakeCnt = 0;
        repeat (32)
        begin
            tbA <= 16'($urandom);
            tbB <= 16'($urandom);
            @(posedge clock);
            step <= 1'b1;
            @(posedge clock);
            step <= 1'b0;
            lvl = ~lvl;
            rise += lvl;
            if (!idl && (m == ICC_BOTH || (m == ICC_FALL && !lvl)
                || (m == ICC_RISE && lvl) || (lvl && m == ICC_DIV4
                && rise % 4 == 0) || (lvl && m == ICC_DIV16
                && rise % 16 == 0)))
            begin
                nc++;
                if (cap.size() < 4)
                    cap.push_back(sel ? tbA : tbB);
            end
            repeat (6) @(posedge clock);
        end
        nIrq = (m == ICC_INT_ONLY && !idl) ? rise : nc / (cpi + 1);
        chk("irq", 33'(irqCnt), 33'(nIrq));
        chk("wake", 33'(wakeCnt), (idl || slp) ? 33'h20 : 33'h0);
        expQ.push_back({19'h0, idl, 5'h0, sel, cpi, nc > 4, nc > 0, m});
        apb(0, 8'(ch * 8), 0);
        foreach (cap[i])
        begin
            expQ.push_back({17'h0, cap[i]});
            apb(0, 8'(ch * 8 + 4), 0);
        end
        expQ.push_back(33'h0);
        apb(0, 8'(ch * 8 + 4), 0);
    endtask
    initial
    begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        {rstn, cpuIdle, cpuSleep, step, chan, tbA, tbB, curCh} = '0;
        apbReq = '0;
        void'($urandom(60730));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        expQ.push_back(33'h0);
        apb(0, 8'h38, 0);
        expQ.push_back({1'b1, 32'h0});
        apb(0, ICC_MAP_END, 0);
        expQ.push_back({1'b1, 32'h0});
        apb(0, 8'h02, 0);
        run(0, ICC_BOTH, 0);
        run(1, ICC_FALL, 0);
        run(2, ICC_RISE, 0);
        run(3, ICC_DIV4, 0);
        run(4, ICC_DIV16, 0);
        run(5, ICC_OFF, 0);
        run(2, ICC_INT_ONLY, 0);
        run(6, ICC_RISE, 1);
        run(7, ICC_BOTH, 0);
        tally_and_finish();
    end
endmodule
